// File: logic/rci_apb_port.sv
// APB slave timing: one wait-free access phase after every setup.
// Assumes a master that follows the APB setup and access sequence.
module rci_apb_port #(
    parameter int unsigned DATA_W = 32
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic              addr_ok,
    input  wire logic [DATA_W-1:0] rdata_in,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   wr_done,
    output logic                   rd_done
);

    logic [DATA_W-1:0] prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;

    wire setup = psel & ~penable;
    wire done  = psel & penable & pready_reg;

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign wr_done = done & pwrite & ~pslverr_reg;
    assign rd_done = done & ~pwrite & ~pslverr_reg;

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            if (setup) begin
                prdata_reg  <= (addr_ok && !pwrite) ? rdata_in : '0;
                pslverr_reg <= ~addr_ok;
            end
        end
    end

endmodule

// File: logic/rci_pkg.sv
// Constants, register map and event encoding of the reset cause indicator.
// Assumes a 32-bit APB slave port and event strobes on the same clock.
package rci_pkg;

    // ==================================================================
    // Bus and register map
    localparam int unsigned RCI_ADDR_W       = 12;
    localparam int unsigned RCI_DATA_W       = 32;
    localparam logic [11:0] RCI_CAUSE_OFS    = 12'h000;
    localparam logic [11:0] RCI_IRQ_STAT_OFS = 12'h004;
    localparam logic [11:0] RCI_IRQ_MASK_OFS = 12'h008;

    // ==================================================================
    // Cause status layout: four flags in bits 7..4, bits 3..0 reserved.
    localparam int unsigned RCI_POR_BIT   = 7;
    localparam int unsigned RCI_STOP_BIT  = 6;
    localparam int unsigned RCI_WDOG_BIT  = 5;
    localparam int unsigned RCI_XRST_BIT  = 4;
    localparam int unsigned RCI_FLAG_LSB  = 4;
    localparam int unsigned RCI_FLAG_W    = 4;
    localparam logic [3:0]  RCI_RSVD_VAL  = 4'h0;

    // Flag patterns, ordered {power_on, stop_recovery, watchdog, external}.
    localparam logic [3:0] RCI_CAUSE_RST = 4'h8;
    localparam logic [3:0] RCI_ROW_POR   = 4'h8;
    localparam logic [3:0] RCI_ROW_XRST  = 4'h1;
    localparam logic [3:0] RCI_ROW_WDOG  = 4'h2;
    localparam logic [3:0] RCI_ROW_OCD   = 4'h8;
    localparam logic [3:0] RCI_ROW_DPIN  = 4'h8;
    localparam logic [3:0] RCI_ROW_GPIO  = 4'h4;
    localparam logic [3:0] RCI_ROW_WWAKE = 4'h6;
    localparam logic [3:0] RCI_ROW_CLR   = 4'h0;

    // ==================================================================
    // Interrupt status and mask layout, one bit per event kind.
    localparam int unsigned RCI_NUM_EVT    = 7;
    localparam int unsigned RCI_IRQ_POR    = 0;
    localparam int unsigned RCI_IRQ_XRST   = 1;
    localparam int unsigned RCI_IRQ_OCD    = 2;
    localparam int unsigned RCI_IRQ_DPIN   = 3;
    localparam int unsigned RCI_IRQ_WDOG   = 4;
    localparam int unsigned RCI_IRQ_WWAKE  = 5;
    localparam int unsigned RCI_IRQ_GPIO   = 6;
    localparam logic [6:0]  RCI_IRQ_RST    = 7'h00;
    localparam logic [6:0]  RCI_MASK_RST   = 7'h00;

    // ==================================================================
    // Winning event of one cycle, highest priority first.
    typedef enum logic [2:0] {
        RCI_EVT_NONE  = 3'b000,
        RCI_EVT_POR   = 3'b001,
        RCI_EVT_XRST  = 3'b010,
        RCI_EVT_OCD   = 3'b011,
        RCI_EVT_DPIN  = 3'b100,
        RCI_EVT_WDOG  = 3'b101,
        RCI_EVT_WWAKE = 3'b110,
        RCI_EVT_GPIO  = 3'b111
    } rci_evt_e;

endpackage

// File: logic/rci_sticky_vec.sv
// Vector of sticky event bits, cleared by writing ones.
// Assumes set strobes and clear requests on the same clock.
module rci_sticky_vec #(
    parameter int unsigned W = 7,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set,
    input  wire logic         clr_en,
    input  wire logic [W-1:0] clr_data,
    output logic      [W-1:0] q
);

    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;
    wire  [W-1:0] clr_bits = clr_en ? clr_data : {W{1'b0}};

    // A set in the clearing cycle wins over the clear.
    assign q_next = (q_reg & ~clr_bits) | set;
    assign q      = q_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg <= RST_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

endmodule

// File: logic/rci_top.sv
// Reset cause indicator: flags that record the last reset or wake source.
// Assumes event strobes are one-cycle pulses from logic on pclk.
//
// What this block does, and what software must do
// RULE1: power-on sets flag; watchdog, stop recovery clear
// RULE2: reading status clears the power-on flag
// RULE3: stop recovery sets the stop-recovery flag
// RULE4: stop plus watchdog flags mark watchdog wake
// RULE5: power-on or running watchdog clears stop flag
// RULE6: reading status clears stop and watchdog flags
// RULE7: watchdog sets flag; power-on, pin wake clear
// RULE8: software reads status before clearing watchdog interrupt
// RULE9: external reset sets flag; power-on, wake, read clear
// RULE10: external reset leaves only the external flag
// RULE11: running watchdog reset leaves only watchdog flag
// RULE12: debugger reset leaves only the power-on flag
// RULE13: debug pin wake leaves only power-on flag
// RULE14: input pin wake leaves only stop flag
// RULE15: watchdog wake leaves stop and watchdog flags
// RULE16: reserved bits read zero, writes are ignored
module rci_top (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [rci_pkg::RCI_ADDR_W-1:0] paddr,
    input  wire logic [rci_pkg::RCI_DATA_W-1:0] pwdata,
    output logic      [rci_pkg::RCI_DATA_W-1:0] prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           por_event,
    input  wire logic                           pin_reset_event,
    input  wire logic                           ocd_reset_req,
    input  wire logic                           debug_pin_wake,
    input  wire logic                           wdog_timeout,
    input  wire logic                           in_stop_mode,
    input  wire logic                           gpio_wake,
    output logic                                irq
);
    import rci_pkg::*;

    // ==================================================================
    // Event classification
    logic [RCI_FLAG_W-1:0]  cause_reg;
    logic [RCI_FLAG_W-1:0]  cause_next;
    logic [RCI_NUM_EVT-1:0] mask_reg;
    logic [RCI_NUM_EVT-1:0] irq_stat;
    logic                   irq_reg;
    rci_evt_e               evt_kind;
    logic [RCI_FLAG_W-1:0]  evt_row;

    wire wdog_run  = wdog_timeout & ~in_stop_mode; // RULE5
    wire wdog_wake = wdog_timeout & in_stop_mode;  // RULE4

    // The highest-priority event of the cycle decides the new flag pattern.
    assign evt_kind = por_event       ? RCI_EVT_POR   :
                      pin_reset_event ? RCI_EVT_XRST  : // RULE9
                      ocd_reset_req   ? RCI_EVT_OCD   :
                      debug_pin_wake  ? RCI_EVT_DPIN  :
                      wdog_run        ? RCI_EVT_WDOG  : // RULE7
                      wdog_wake       ? RCI_EVT_WWAKE :
                      gpio_wake       ? RCI_EVT_GPIO  : RCI_EVT_NONE;

    always_comb begin
        case (evt_kind)
            RCI_EVT_POR:   evt_row = RCI_ROW_POR;   // RULE1
            RCI_EVT_XRST:  evt_row = RCI_ROW_XRST;  // RULE10
            RCI_EVT_OCD:   evt_row = RCI_ROW_OCD;   // RULE12
            RCI_EVT_DPIN:  evt_row = RCI_ROW_DPIN;  // RULE13
            RCI_EVT_WDOG:  evt_row = RCI_ROW_WDOG;  // RULE11
            RCI_EVT_WWAKE: evt_row = RCI_ROW_WWAKE; // RULE15
            RCI_EVT_GPIO:  evt_row = RCI_ROW_GPIO;  // RULE14
            default:       evt_row = cause_reg;
        endcase
    end

    // ==================================================================
    // Register bus
    logic [RCI_DATA_W-1:0] rdata_mux;
    logic                  wr_done;
    logic                  rd_done;

    wire sel_cause = (paddr == RCI_CAUSE_OFS);
    wire sel_stat  = (paddr == RCI_IRQ_STAT_OFS);
    wire sel_mask  = (paddr == RCI_IRQ_MASK_OFS);
    wire addr_ok   = sel_cause | sel_stat | sel_mask;

    wire [RCI_DATA_W-1:0] cause_word = {{(RCI_DATA_W-8){1'b0}}, cause_reg, RCI_RSVD_VAL}; // RULE16
    wire [RCI_DATA_W-1:0] stat_word  = {{(RCI_DATA_W-RCI_NUM_EVT){1'b0}}, irq_stat};
    wire [RCI_DATA_W-1:0] mask_word  = {{(RCI_DATA_W-RCI_NUM_EVT){1'b0}}, mask_reg};

    assign rdata_mux = sel_cause ? cause_word :
                       sel_stat  ? stat_word  :
                       sel_mask  ? mask_word  : '0;

    rci_apb_port #(
        .DATA_W   (RCI_DATA_W)
    ) u_apb (
        .pclk     (pclk),
        .presetn  (presetn),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .addr_ok  (addr_ok),
        .rdata_in (rdata_mux),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .wr_done  (wr_done),
        .rd_done  (rd_done)
    );

    wire cause_rd  = rd_done & sel_cause;
    wire cause_wr  = wr_done & sel_cause;
    wire stat_wr   = wr_done & sel_stat;
    wire mask_wr   = wr_done & sel_mask;
    wire evt_any   = (evt_kind != RCI_EVT_NONE);

    // A read only clears what it returned: a pattern loaded after the
    // capture of the read data survives the clearing edge.
    wire rd_match  = (cause_reg == prdata[RCI_FLAG_LSB +: RCI_FLAG_W]);
    wire rd_clear  = cause_rd & rd_match;

    // ==================================================================
    // Cause flags
    // An event in the read-clear cycle wins; bus writes never reach here.
    assign cause_next = evt_any  ? evt_row     : // RULE3
                        rd_clear ? RCI_ROW_CLR : // RULE2
                        cause_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_reg <= RCI_CAUSE_RST;
        end else begin
            cause_reg <= cause_next; // RULE6
        end
    end

    // ==================================================================
    // Interrupts
    wire [RCI_NUM_EVT-1:0] evt_vec = {gpio_wake, wdog_wake, wdog_run, debug_pin_wake,
                                      ocd_reset_req, pin_reset_event, por_event};

    rci_sticky_vec #(
        .W        (RCI_NUM_EVT),
        .RST_VAL  (RCI_IRQ_RST)
    ) u_irq_stat (
        .pclk     (pclk),
        .presetn  (presetn),
        .set      (evt_vec),
        .clr_en   (stat_wr),
        .clr_data (pwdata[RCI_NUM_EVT-1:0]),
        .q        (irq_stat)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= RCI_MASK_RST;
            irq_reg  <= 1'b0;
        end else begin
            if (mask_wr) begin
                mask_reg <= pwdata[RCI_NUM_EVT-1:0];
            end
            irq_reg <= |(irq_stat & mask_reg);
        end
    end

    assign irq = irq_reg;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_por_row;
        por_event |=> (cause_reg == 4'b1000);
    endproperty
    a_por_row: assert property (p_por_row) else $error("power-on row wrong"); // RULE1

    property p_rd_clr_por;
        (rd_clear && !evt_any) |=> !cause_reg[3];
    endproperty
    a_rd_clr_por: assert property (p_rd_clr_por) else $error("read kept power-on flag"); // RULE2

    property p_stop_set;
        (wdog_wake || gpio_wake) && !por_event && !pin_reset_event
            && !ocd_reset_req && !debug_pin_wake && !wdog_run |=> cause_reg[2];
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("stop flag not set"); // RULE3

    property p_stop_wdt_pair;
        (evt_kind == RCI_EVT_WWAKE) |=> (cause_reg[2:1] == 2'b11);
    endproperty
    a_stop_wdt_pair: assert property (p_stop_wdt_pair) else $error("wake pair wrong"); // RULE4

    property p_stop_clr;
        (por_event || (wdog_run && !pin_reset_event && !ocd_reset_req && !debug_pin_wake))
            |=> !cause_reg[2];
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("stop flag not cleared"); // RULE5

    property p_rd_clr_all;
        (rd_clear && !evt_any) |=> (cause_reg[2:0] == 3'b000);
    endproperty
    a_rd_clr_all: assert property (p_rd_clr_all) else $error("read kept flags"); // RULE6

    property p_wdog_clr;
        (evt_kind == RCI_EVT_GPIO) |=> !cause_reg[1];
    endproperty
    a_wdog_clr: assert property (p_wdog_clr) else $error("pin wake kept watchdog flag"); // RULE7

    property p_xrst_row;
        (evt_kind == RCI_EVT_XRST) |=> (cause_reg == 4'b0001) ##1 (cause_reg == 4'b0001 || evt_any
            || $past(rd_clear) || $past(evt_any));
    endproperty
    a_xrst_row: assert property (p_xrst_row) else $error("external row wrong"); // RULE10

    property p_wdog_row;
        (evt_kind == RCI_EVT_WDOG) |=> (cause_reg == 4'b0010);
    endproperty
    a_wdog_row: assert property (p_wdog_row) else $error("watchdog row wrong"); // RULE11

    property p_debug_rows;
        (evt_kind == RCI_EVT_OCD || evt_kind == RCI_EVT_DPIN) |=> (cause_reg == 4'b1000);
    endproperty
    a_debug_rows: assert property (p_debug_rows) else $error("debug row wrong"); // RULE12

    property p_gpio_row;
        (evt_kind == RCI_EVT_GPIO) |=> (cause_reg == 4'b0100);
    endproperty
    a_gpio_row: assert property (p_gpio_row) else $error("pin wake row wrong"); // RULE14

    property p_rsvd_zero;
        (cause_rd) |-> (prdata[3:0] == 4'h0 && prdata[31:8] == 24'h000000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero"); // RULE16

    property p_wr_ignored;
        (cause_wr && !evt_any) |=> $stable(cause_reg);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("write changed flags"); // RULE16

    property p_xrst_clr_read;
        (rd_clear && !evt_any) ##1 !evt_any |=> (cause_reg == 4'b0000);
    endproperty
    a_xrst_clr_read: assert property (p_xrst_clr_read) else $error("read kept external flag"); // RULE9

    property p_irq_level;
        ##1 (irq == $past(|(irq_stat & mask_reg)));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    // ==================================================================
    // Assertions on single flags and on the read path
    // The external, watchdog and power-on flags are checked on their own, so that a wrong
    // row entry shows up as the one flag that it breaks; two rows are checked whole.
    property p_wwake_row;
        (evt_kind == RCI_EVT_WWAKE) |=> (cause_reg == 4'h6);
    endproperty
    a_wwake_row: assert property (p_wwake_row) else $error("watchdog wake row wrong"); // RULE15

    property p_dpin_row;
        (evt_kind == RCI_EVT_DPIN) |=> (cause_reg == 4'h8);
    endproperty
    a_dpin_row: assert property (p_dpin_row) else $error("debug pin row wrong"); // RULE13

    property p_xrst_set;
        (evt_kind == RCI_EVT_XRST) |=> cause_reg[0];
    endproperty
    a_xrst_set: assert property (p_xrst_set) else $error("external flag not set"); // RULE9

    property p_xrst_clr;
        (por_event || evt_kind == RCI_EVT_GPIO) |=> !cause_reg[0];
    endproperty
    a_xrst_clr: assert property (p_xrst_clr) else $error("external flag not cleared"); // RULE9

    property p_wdog_set;
        (evt_kind == RCI_EVT_WDOG || evt_kind == RCI_EVT_WWAKE) |=> cause_reg[1];
    endproperty
    a_wdog_set: assert property (p_wdog_set) else $error("watchdog flag not set"); // RULE7

    property p_wdog_clr_por;
        por_event |=> !cause_reg[1];
    endproperty
    a_wdog_clr_por: assert property (p_wdog_clr_por) else $error("power-on kept watchdog"); // RULE7

    property p_por_clr;
        (evt_kind == RCI_EVT_WDOG || evt_kind == RCI_EVT_WWAKE
            || evt_kind == RCI_EVT_GPIO) |=> !cause_reg[3];
    endproperty
    a_por_clr: assert property (p_por_clr) else $error("power-on flag not cleared"); // RULE1

    property p_stop_no_wdog;
        (evt_kind == RCI_EVT_GPIO) |=> (cause_reg[2:1] == 2'b10);
    endproperty
    a_stop_no_wdog: assert property (p_stop_no_wdog) else $error("pin wake pair wrong"); // RULE4

    // The returned flags are those that stood when the setup was taken.
    property p_rd_data;
        cause_rd |-> (prdata[7:4] == $past(cause_reg));
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read returned wrong flags"); // RULE2

    property p_flags_hold;
        (!evt_any && !rd_clear) |=> $stable(cause_reg);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags changed unprompted"); // RULE6

    property p_pready_pulse;
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");

endmodule

// File: testbench/test_rci_top.sv
// Self-checking bench for the reset cause indicator, driving APB and event strobes.
// Assumes the design files under logic/ are compiled first, the package before the top.
module test_rci_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rci_pkg::*;

    // ==================================================================
    // Signals
    logic                  pclk;
    logic                  presetn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [RCI_ADDR_W-1:0] paddr;
    logic [RCI_DATA_W-1:0] pwdata;
    logic [RCI_DATA_W-1:0] prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  por_event;
    logic                  pin_reset_event;
    logic                  ocd_reset_req;
    logic                  debug_pin_wake;
    logic                  wdog_timeout;
    logic                  in_stop_mode;
    logic                  gpio_wake;
    logic                  irq;
    int                    bad_count;
    int                    checks;
    logic [31:0]           rd;
    logic                  er;
    // Expected flags {power_on, stop, watchdog, external} per event kind:
    // power-on, external, debugger, debug pin, running watchdog, watchdog wake, pin wake.
    logic [3:0]            rows [7] = '{4'h8, 4'h1, 4'h8, 4'h8, 4'h2, 4'h6, 4'h4};
    int                    pair_a [5] = '{5, 1, 6, 0, 0};
    int                    pair_b [5] = '{6, 6, 4, 4, 5};
    logic [3:0]            pair_x [5] = '{4'h4, 4'h4, 4'h2, 4'h2, 4'h6};

    rci_top uut (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .por_event       (por_event),
        .pin_reset_event (pin_reset_event),
        .ocd_reset_req   (ocd_reset_req),
        .debug_pin_wake  (debug_pin_wake),
        .wdog_timeout    (wdog_timeout),
        .in_stop_mode    (in_stop_mode),
        .gpio_wake       (gpio_wake),
        .irq             (irq)
    );

    // ==================================================================
    // Clock and tasks
    always #2.5 pclk = ~pclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Fires one event kind for one cycle; kind 5 is a watchdog timeout while stopped.
    task automatic fire(input int k);
        @(posedge pclk);
        por_event       <= (k == 0);
        pin_reset_event <= (k == 1);
        ocd_reset_req   <= (k == 2);
        debug_pin_wake  <= (k == 3);
        wdog_timeout    <= (k == 4 || k == 5);
        in_stop_mode    <= (k == 5);
        gpio_wake       <= (k == 6);
        @(posedge pclk);
        {por_event, pin_reset_event, ocd_reset_req, debug_pin_wake} <= 4'h0;
        {wdog_timeout, in_stop_mode, gpio_wake} <= 3'h0;
    endtask

    task automatic read_cause(input logic [3:0] f);
        apb(1'b0, RCI_CAUSE_OFS, 32'h0);
        chk(rd, {24'h0, f, 4'h0});
        chk({31'h0, er}, 32'h0);
    endtask

    task automatic complete_run;
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==================================================================
    // Tests
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {por_event, pin_reset_event, ocd_reset_req, debug_pin_wake} = 4'h0;
        {wdog_timeout, in_stop_mode, gpio_wake} = 3'h0;
        bad_count = 0;
        checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        read_cause(4'h8);
        read_cause(4'h0);
        apb(1'b0, RCI_IRQ_MASK_OFS, 32'h0);
        chk(rd, 32'h0);
        for (int k = 0; k < 7; k++) begin
            fire(k);
            read_cause(rows[k]);
            read_cause(4'h0);
        end
        for (int p = 0; p < 5; p++) begin
            fire(pair_a[p]);
            fire(pair_b[p]);
            read_cause(pair_x[p]);
        end
        fire(1);
        apb(1'b1, RCI_CAUSE_OFS, 32'hffff_ffff);
        chk({31'h0, er}, 32'h0);
        read_cause(4'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        // Every event kind has fired, so all status bits are set while masked off.
        apb(1'b0, RCI_IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'h7f);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, RCI_IRQ_STAT_OFS, 32'h7f);
        apb(1'b0, RCI_IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, RCI_IRQ_MASK_OFS, 32'h10);
        fire(4);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        read_cause(4'h2);
        apb(1'b1, RCI_IRQ_STAT_OFS, 32'h10);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        fire(6);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, RCI_IRQ_MASK_OFS, 32'h40);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, RCI_IRQ_MASK_OFS, 32'h0);
        chk(rd, 32'h40);
        apb(1'b1, RCI_IRQ_STAT_OFS, 32'h40);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // A second reset in mid-run brings back the power-on pattern.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        read_cause(4'h8);
        apb(1'b0, RCI_IRQ_MASK_OFS, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
        complete_run();
    end

    initial begin
        #100000;
        bad_count++;
        complete_run();
    end
endmodule
